/* hw/alarm_rotator.sv */
// Round-robin pick of the active alarm shown
`timescale 1ns/1ps
module alarm_rotator #(
	parameter int N = fpd_pkg::ALARM_COUNT
) (
	// Clock and reset
	input wire logic i_clock,
	input wire logic i_nrst,
	// Active alarms and move request
	input wire logic [N-1:0] i_active,
	input wire logic i_advance,
	// Current alarm
	output logic [5:0] o_index
);
	import fpd_pkg::*;

	// Next active alarm after cur, circularly
	function automatic logic [5:0] next_active(input logic [N-1:0] vec, input logic [5:0] cur);
		int j;
		logic found;
		next_active = cur;
		found = 1'b0;
		for (int k = 1; k <= N; k++) begin
			j = (int'(cur) + k) % N;
			if (!found && vec[j]) begin
				next_active = 6'(j);
				found = 1'b1;
			end
		end
	endfunction

	logic [5:0] index_q;
	wire move = i_advance || !i_active[index_q];

	// Step to the next alarm on request or when current clears
	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			index_q <= 6'h00;
		end else if (move) begin
			index_q <= next_active(i_active, index_q); //RULE13
		end
	end

	assign o_index = index_q;
endmodule

/* hw/alarm_text_rom.sv */
// Status text and length for each alarm index
`timescale 1ns/1ps
module alarm_text_rom (
	// Alarm selection
	input wire logic [5:0] i_index,
	// Text, left justified, and its length
	output logic [fpd_pkg::ALARM_CHARS*8-1:0] o_text,
	output logic [6:0] o_len
);
	import fpd_pkg::*;

	// Supply name, four characters
	function automatic logic [31:0] supply_name(input int s);
		case (s)
			0: supply_name = "+5V ";
			1: supply_name = "-5V ";
			2: supply_name = "-2V ";
			3: supply_name = "+24V";
			4: supply_name = "-24V";
			5: supply_name = "+12V";
			default: supply_name = "-12V";
		endcase
	endfunction

	// Decimal digit character
	function automatic logic [7:0] digit(input int n);
		digit = CHAR_ZERO + 8'(n);
	endfunction

	int idx;
	int sup;
	logic [15:0] kind;
	logic [31:0] name;

	// Per class text build
	always_comb begin
		idx = int'(i_index);
		sup = idx % SUPPLIES;
		name = supply_name(sup);
		kind = (idx < ALM_UV) ? "OV" : (idx < ALM_OC) ? "UV" : "OC";
		o_text = "            ";
		o_len = 7'h00;
		if (idx < ALM_FAN) begin
			// Supply over/under voltage and over current
			if (sup < SHORT_NAMES) begin
				o_text = {name[31:8], " PS ", kind, "   "}; //RULE12
				o_len = 7'h09;
			end else begin
				o_text = {name, " PS ", kind, "  "};
				o_len = 7'h0A;
			end
		end else if (idx < ALM_AMB) begin
			o_text = {"FAN ", digit(idx - ALM_FAN + 1), " SPEED "};
			o_len = 7'h0B;
		end else if (idx == ALM_AMB) begin
			o_text = "AMB TEMP H  ";
			o_len = 7'h0A;
		end else if (idx < ALM_SLOT + 9) begin
			o_text = {"SLOT ", digit(idx - ALM_SLOT + 1), " T    "};
			o_len = 7'h08;
		end else if (idx < ALM_IACK) begin
			o_text = {"SLOT 1", digit(idx - ALM_SLOT - 9), " T   "};
			o_len = 7'h09;
		end else if (idx < ALM_BERR) begin
			o_text = {"IACK", digit(idx - ALM_IACK + 1), " CNT   "};
			o_len = 7'h09;
		end else begin
			// Single entries
			case (idx)
				ALM_BERR: begin
					o_text = "BERR CNT    ";
					o_len = 7'h08;
				end
				ALM_SYSF: begin
					o_text = "SYSFAIL     ";
					o_len = 7'h07;
				end
				ALM_ACF: begin
					o_text = "ACFAIL      ";
					o_len = 7'h06;
				end
				ALM_PON: begin
					o_text = "PON TIME    ";
					o_len = 7'h08;
				end
				ALM_TPON: begin
					o_text = "TOT PON TM  ";
					o_len = 7'h0A;
				end
				default: begin
					o_text = "FILTER      ";
					o_len = 7'h06;
				end
			endcase
		end
	end
endmodule

/* hw/fpd_pkg.sv */
// Shared constants, types and register map of the front panel display controller
package fpd_pkg;
	// Clock and scroll timing
	localparam int CLOCK_HZ = 25_000_000;
	localparam int SCROLL_CPS = 2;
	localparam int STEP_CYCLES = CLOCK_HZ / SCROLL_CPS;
	localparam int DWELL_STEPS = 4;
	// Display geometry
	localparam int DISP_POS = 10;
	localparam int TEXT_POS = 9;
	localparam int MSG_MAX = 80;
	localparam int ALARM_CHARS = 12;
	localparam int ALARM_COUNT = 50;
	// Register byte offsets
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_TEXT_START = 8'h08;
	localparam logic [7:0] ADDR_TEXT_CHAR = 8'h0C;
	localparam logic [7:0] ADDR_READBACK = 8'h10;
	// Field positions
	localparam int CTRL_EN_BIT = 0;
	localparam int CTRL_RST_BIT = 1;
	localparam int CTRL_CLR_BIT = 2;
	localparam int STAT_EN_BIT = 0;
	localparam int STAT_DEF_BIT = 1;
	localparam int STAT_LEN_LSB = 8;
	localparam int STAT_LINE_BIT = 16;
	localparam int STAT_ALARM_BIT = 17;
	localparam int RB_VALID_BIT = 8;
	localparam int RB_LAST_BIT = 9;
	// Reset values
	localparam logic ENABLE_RST = 1'b1;
	// Alarm index bases
	localparam int ALM_OV = 0;
	localparam int ALM_UV = 7;
	localparam int ALM_OC = 14;
	localparam int ALM_FAN = 21;
	localparam int ALM_AMB = 24;
	localparam int ALM_SLOT = 25;
	localparam int ALM_IACK = 37;
	localparam int ALM_BERR = 44;
	localparam int ALM_SYSF = 45;
	localparam int ALM_ACF = 46;
	localparam int ALM_PON = 47;
	localparam int ALM_TPON = 48;
	localparam int ALM_FILT = 49;
	localparam int SUPPLIES = 7;
	localparam int SHORT_NAMES = 3;
	// Character codes
	localparam logic [7:0] CHAR_SPACE = 8'h20;
	localparam logic [7:0] CHAR_DQ = 8'h22;
	localparam logic [7:0] CHAR_SQ = 8'h27;
	localparam logic [7:0] CHAR_ZERO = 8'h30;
	// Idle texts, left justified
	localparam logic [ALARM_CHARS*8-1:0] TXT_OK = "System OK   ";
	localparam logic [ALARM_CHARS*8-1:0] TXT_STANDBY = "Standby     ";
	localparam logic [6:0] LEN_OK = 7'h09;
	localparam logic [6:0] LEN_STANDBY = 7'h07;
	// What the display shows
	typedef enum {SRC_BLANK, SRC_ALARM, SRC_USER, SRC_OK, SRC_STANDBY} source_e;
	// Readback sequencer phases
	typedef enum {RB_OPEN, RB_BODY, RB_DUP, RB_CLOSE, RB_DONE} readback_e;
	// Register port request
	typedef struct packed {
		logic [7:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} regbus_s;
	// Display frame: chars[0] leftmost, chars[9] the status clock
	typedef struct packed {
		logic lit;
		logic [DISP_POS-1:0][7:0] chars;
	} display_s;
endpackage

/* hw/front_panel_text_display_ctrl.sv */
// Front panel text display controller: source selection, scroll, flash, user text
//
// Operation
// RULE1: Display enabled at power-up and reset command.
// RULE2: Disabled display is blank, shows no text.
// RULE3: Enable query reads 0 off, 1 on.
// RULE4: User text holds zero to 80 characters.
// RULE5: Rightmost position is status clock; nine text.
// RULE6: Long text scrolls one character per half second.
// RULE7: Readback is quoted, embedded quotes doubled.
// RULE8: Sender may delimit with double or single quote.
// RULE9: Empty user text blanks display unless alarm.
// RULE10: Clear discards text, as if never defined.
// RULE11: Priority: alarm, user, system OK, standby.
// RULE12: Each alarm class has its own text.
// RULE13: Alarm texts flash and rotate round-robin.
// RULE14: Every printable character code reaches the display.
// RULE15: Scroll restarts one step after final window.
//
// Decided for this implementation: strobed register access and the address map.
`timescale 1ns/1ps
module front_panel_text_display_ctrl #(
	parameter int STEP_CYCLES_P = fpd_pkg::STEP_CYCLES,
	parameter int MSG_MAX_P = fpd_pkg::MSG_MAX
) (
	// Clock and reset
	input wire logic i_clock,
	input wire logic i_nrst,
	// Register port
	input wire fpd_pkg::regbus_s i_bus,
	output logic [31:0] o_rdata,
	// Monitored conditions
	input wire logic [fpd_pkg::ALARM_COUNT-1:0] i_alarm,
	input wire logic i_line_on,
	// Display drive
	output fpd_pkg::display_s o_display
);
	import fpd_pkg::*;

	localparam int LEN_W = 7;
	localparam int STEP_W = $clog2(STEP_CYCLES_P);

	// Stored user text
	logic [7:0] msg_q [MSG_MAX_P];
	logic [LEN_W-1:0] len_q;
	logic defined_q;
	logic open_q;
	logic [7:0] delim_q;
	// Display state
	logic enable_q;
	logic [STEP_W-1:0] tick_q;
	logic [6:0] scroll_q;
	logic [2:0] dwell_q;
	logic flash_q;
	logic [1:0] spin_q;
	logic [8:0] key_q;
	// Readback sequencer
	readback_e rb_q;
	logic [LEN_W-1:0] rb_ptr_q;
	// Output registers
	logic [31:0] rdata_q;
	display_s disp_q;

	// Address decode
	wire hit_ctrl = i_bus.addr == ADDR_CTRL;
	wire hit_stat = i_bus.addr == ADDR_STATUS;
	wire hit_start = i_bus.addr == ADDR_TEXT_START;
	wire hit_char = i_bus.addr == ADDR_TEXT_CHAR;
	wire hit_rb = i_bus.addr == ADDR_READBACK;
	wire wr_ctrl = i_bus.wr && hit_ctrl;
	wire wr_start = i_bus.wr && hit_start;
	wire wr_char = i_bus.wr && hit_char;
	wire rd_rb = i_bus.rd && hit_rb;
	wire rst_cmd = wr_ctrl && i_bus.wdata[CTRL_RST_BIT];
	wire clr_cmd = wr_ctrl && i_bus.wdata[CTRL_CLR_BIT];
	wire [7:0] wchar = i_bus.wdata[7:0];
	// Closing delimiter ends the string
	wire char_end = wr_char && open_q && (wchar == delim_q);
	// Append while open and below capacity
	wire char_ok = wr_char && open_q && !char_end && (len_q < LEN_W'(MSG_MAX_P));
	// A quote start character is the delimiter; any other start makes code 00 the delimiter
	wire start_quoted = (wchar == CHAR_DQ) || (wchar == CHAR_SQ);
	wire rb_restart = (i_bus.wr && hit_rb) || wr_start || clr_cmd;

	// Alarm text and rotation
	wire any_alarm = |i_alarm;
	wire [5:0] alm_idx;
	wire [ALARM_CHARS*8-1:0] alm_text;
	wire [6:0] alm_len;
	wire step = tick_q == STEP_W'(STEP_CYCLES_P - 1);
	source_e src;
	wire advance = step && (src == SRC_ALARM) && (dwell_q == 3'(DWELL_STEPS - 1));

	alarm_rotator #(
		.N(ALARM_COUNT)
	) u_rotator (
		.i_clock(i_clock),
		.i_nrst(i_nrst),
		.i_active(i_alarm),
		.i_advance(advance),
		.o_index(alm_idx)
	);

	alarm_text_rom u_rom (
		.i_index(alm_idx),
		.o_text(alm_text),
		.o_len(alm_len)
	);

	// Source priority
	assign src = !enable_q ? SRC_BLANK : //RULE2
		any_alarm ? SRC_ALARM : //RULE11
		defined_q ? SRC_USER : //RULE10
		i_line_on ? SRC_OK : SRC_STANDBY;
	// Length and text of the current source
	wire [6:0] src_len = (src == SRC_USER) ? len_q : //RULE9
		(src == SRC_ALARM) ? alm_len :
		(src == SRC_OK) ? LEN_OK :
		(src == SRC_STANDBY) ? LEN_STANDBY : 7'h00;
	wire [ALARM_CHARS*8-1:0] src_text = (src == SRC_ALARM) ? alm_text :
		(src == SRC_OK) ? TXT_OK : TXT_STANDBY;
	// Last window start; zero when text fits
	wire [6:0] last_off = (src_len > 7'(TEXT_POS)) ? src_len - 7'(TEXT_POS) : 7'h00;
	// A new source or alarm starts at its first window
	wire [8:0] key = {3'(src), alm_idx};
	wire restart = (key != key_q) || wr_start || clr_cmd;

	// Character i of a left-justified fixed text
	function automatic logic [7:0] text_char(input logic [ALARM_CHARS*8-1:0] t, input logic [6:0] i);
		text_char = CHAR_SPACE;
		for (int k = 0; k < ALARM_CHARS; k++) begin
			if (7'(k) == i) begin
				text_char = t[(ALARM_CHARS - 1 - k)*8 +: 8];
			end
		end
	endfunction

	// Status clock glyph
	function automatic logic [7:0] spin_glyph(input logic [1:0] s);
		case (s)
			2'h0: spin_glyph = "|";
			2'h1: spin_glyph = "/";
			2'h2: spin_glyph = "-";
			default: spin_glyph = "\\";
		endcase
	endfunction

	// Next display frame
	display_s disp_d;
	logic [6:0] pos;
	logic [7:0] ch;
	always_comb begin
		pos = 7'h00;
		ch = CHAR_SPACE;
		disp_d.lit = enable_q;
		disp_d.chars = {DISP_POS{CHAR_SPACE}};
		for (int p = 0; p < TEXT_POS; p++) begin
			pos = scroll_q + 7'(p);
			ch = (src == SRC_USER) ? msg_q[pos < 7'(MSG_MAX_P) ? pos : 7'h00] : text_char(src_text, pos);
			// Blank past the end, when off, and in the dark flash phase
			if (enable_q && (pos < src_len) && !((src == SRC_ALARM) && !flash_q)) begin
				disp_d.chars[p] = ch; //RULE14
			end
		end
		if (enable_q) begin
			disp_d.chars[DISP_POS-1] = spin_glyph(spin_q); //RULE5
		end
	end

	// Readback sequencer next state and answer
	readback_e rb_d;
	logic [LEN_W-1:0] rb_ptr_d;
	logic [7:0] rb_char;
	logic rb_valid;
	logic rb_last;
	logic rb_end;
	always_comb begin
		rb_d = rb_q;
		rb_ptr_d = rb_ptr_q;
		rb_char = CHAR_DQ;
		rb_valid = 1'b1;
		rb_last = 1'b0;
		rb_end = (rb_ptr_q + 7'h01) >= len_q;
		case (rb_q)
			RB_OPEN: begin
				rb_d = (defined_q && (len_q != 7'h00)) ? RB_BODY : RB_CLOSE; //RULE7
			end
			RB_BODY: begin
				rb_char = msg_q[rb_ptr_q];
				if (msg_q[rb_ptr_q] == CHAR_DQ) begin
					rb_d = RB_DUP; //RULE7
				end else begin
					rb_d = rb_end ? RB_CLOSE : RB_BODY;
					rb_ptr_d = rb_ptr_q + 7'h01;
				end
			end
			RB_DUP: begin
				rb_d = rb_end ? RB_CLOSE : RB_BODY;
				rb_ptr_d = rb_ptr_q + 7'h01;
			end
			RB_CLOSE: begin
				rb_last = 1'b1;
				rb_d = RB_DONE;
			end
			default: begin
				rb_char = 8'h00;
				rb_valid = 1'b0;
			end
		endcase
	end

	// Read data selection
	logic [31:0] rdata_d;
	always_comb begin
		rdata_d = 32'h0000_0000;
		if (i_bus.rd && hit_ctrl) begin
			rdata_d[CTRL_EN_BIT] = enable_q; //RULE3
		end else if (i_bus.rd && hit_stat) begin
			rdata_d[STAT_EN_BIT] = enable_q;
			rdata_d[STAT_DEF_BIT] = defined_q;
			rdata_d[STAT_LEN_LSB +: LEN_W] = len_q;
			rdata_d[STAT_LINE_BIT] = i_line_on;
			rdata_d[STAT_ALARM_BIT] = any_alarm;
		end else if (rd_rb) begin
			rdata_d[7:0] = rb_char;
			rdata_d[RB_VALID_BIT] = rb_valid;
			rdata_d[RB_LAST_BIT] = rb_last;
		end
	end

	// Text storage, no reset needed for data
	always_ff @(posedge i_clock) begin
		if (char_ok) begin
			msg_q[len_q] <= wchar;
		end
	end

	// Text control: start, append, close, clear
	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			len_q <= 7'h00;
			defined_q <= 1'b0;
			open_q <= 1'b0;
			delim_q <= 8'h00;
		end else if (clr_cmd) begin
			len_q <= 7'h00; //RULE10
			defined_q <= 1'b0;
			open_q <= 1'b0;
		end else if (wr_start) begin
			len_q <= 7'h00; //RULE4
			defined_q <= 1'b1;
			open_q <= 1'b1;
			delim_q <= start_quoted ? wchar : 8'h00; //RULE8
		end else if (char_end) begin
			open_q <= 1'b0;
		end else if (char_ok) begin
			len_q <= len_q + 7'h01; //RULE4
		end
	end

	// Display enable
	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			enable_q <= ENABLE_RST; //RULE1
		end else if (rst_cmd) begin
			enable_q <= ENABLE_RST; //RULE1
		end else if (wr_ctrl) begin
			enable_q <= i_bus.wdata[CTRL_EN_BIT];
		end
	end

	// Step timer at the scroll rate
	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			tick_q <= '0;
		end else begin
			tick_q <= step ? '0 : tick_q + 1'b1; //RULE6
		end
	end

	// Scroll window, flash phase, dwell and status clock
	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			scroll_q <= 7'h00;
			flash_q <= 1'b1;
			dwell_q <= 3'h0;
			spin_q <= 2'h0;
			key_q <= 9'h000;
		end else begin
			key_q <= key;
			if (step) begin
				spin_q <= spin_q + 2'h1;
			end
			if (restart) begin
				scroll_q <= 7'h00;
				flash_q <= 1'b1;
				dwell_q <= 3'h0;
			end else if (step) begin
				scroll_q <= (scroll_q >= last_off) ? 7'h00 : scroll_q + 7'h01; //RULE15
				flash_q <= !flash_q; //RULE13
				dwell_q <= dwell_q + 3'h1;
			end
		end
	end

	// Readback position
	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			rb_q <= RB_OPEN;
			rb_ptr_q <= 7'h00;
		end else if (rb_restart) begin
			rb_q <= RB_OPEN;
			rb_ptr_q <= 7'h00;
		end else if (rd_rb) begin
			rb_q <= rb_d;
			rb_ptr_q <= rb_ptr_d;
		end
	end

	// Registered outputs
	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			rdata_q <= 32'h0000_0000;
			disp_q <= '0;
		end else begin
			rdata_q <= rdata_d;
			disp_q <= disp_d;
		end
	end

	assign o_rdata = rdata_q;
	assign o_display = disp_q;
endmodule

/* tb/fpd_monitor.sv */
// Port-level checker of the front panel display controller
`timescale 1ns/1ps
module fpd_monitor #(
	parameter int STEP_CYCLES_P = 8,
	parameter int MSG_MAX_P = 80
) (
	// Clock and reset
	input wire logic i_clock,
	input wire logic i_nrst,
	// Register port
	input wire fpd_pkg::regbus_s i_bus,
	input wire logic [31:0] o_rdata,
	// Conditions and display
	input wire logic [fpd_pkg::ALARM_COUNT-1:0] i_alarm,
	input wire logic i_line_on,
	input wire fpd_pkg::display_s o_display
);
	import fpd_pkg::*;
	// Glyph history and cycles since it last moved
	logic [7:0] glyph_q;
	int hold_q;
	int hold_d;
	logic lit_q;
	logic valid_q;
	logic valid_d;
	wire chg = o_display.chars[9] != glyph_q;
	assign hold_d = chg ? 0 : hold_q + 1;
	// Only a move seen while lit on both sides starts a trusted span
	assign valid_d = o_display.lit && (valid_q || (chg && lit_q));
	// Track glyph moves
	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			glyph_q <= 8'h00;
			hold_q <= 0;
			lit_q <= 1'b0;
			valid_q <= 1'b0;
		end else begin
			glyph_q <= o_display.chars[9];
			hold_q <= hold_d;
			lit_q <= o_display.lit;
			valid_q <= valid_d;
		end
	end
	default clocking @(posedge i_clock);
	endclocking
	default disable iff (!i_nrst);
	AST_RD_IDLE: assert property ($past(i_nrst) && !$past(i_bus.rd) |-> o_rdata == 32'h0000_0000)
		else $error("Read data nonzero outside an answer");
	AST_EN_QUERY: assert property ($past(i_bus.rd) && $past(i_bus.addr) == ADDR_CTRL |->
		o_rdata == {31'h0000_0000, o_display.lit}) else $error("Enable query differs from display state");
	AST_STATUS_EN: assert property ($past(i_bus.rd) && $past(i_bus.addr) == ADDR_STATUS |->
		o_rdata[0] == o_display.lit && o_rdata[31:18] == 14'h0000) else $error("Status enable bit wrong");
	AST_LEN_MAX: assert property ($past(i_bus.rd) && $past(i_bus.addr) == ADDR_STATUS |->
		o_rdata[14:8] <= MSG_MAX_P) else $error("Stored length above maximum");
	AST_OFF_BLANK: assert property ($past(i_nrst) && !o_display.lit |->
		o_display.chars == {DISP_POS{CHAR_SPACE}}) else $error("Dark display not blank");
	AST_GLYPH: assert property ($past(i_nrst) && o_display.lit |->
		o_display.chars[9] inside {8'h7C, 8'h2F, 8'h2D, 8'h5C}) else $error("Rightmost position not the glyph");
	AST_DISABLE: assert property (i_bus.wr && i_bus.addr == ADDR_CTRL && i_bus.wdata[1:0] == 2'h0 |->
		##[1:2] !o_display.lit) else $error("Display stayed lit after switch off");
	AST_RST_CMD: assert property (i_bus.wr && i_bus.addr == ADDR_CTRL && i_bus.wdata[1] |->
		##[1:2] o_display.lit) else $error("Reset command left display dark");
	AST_QUOTE_LAST: assert property ($past(i_bus.rd) && $past(i_bus.addr) == ADDR_READBACK && o_rdata[9] |->
		o_rdata[8] && o_rdata[7:0] == CHAR_DQ) else $error("Readback does not close with a quote");
	AST_STEP: assert property (chg && valid_q && o_display.lit |-> hold_q >= STEP_CYCLES_P - 1)
		else $error("Step shorter than its period");
endmodule
bind front_panel_text_display_ctrl fpd_monitor #(.STEP_CYCLES_P(STEP_CYCLES_P), .MSG_MAX_P(MSG_MAX_P)) mon (
	.i_clock(i_clock), .i_nrst(i_nrst), .i_bus(i_bus), .o_rdata(o_rdata),
	.i_alarm(i_alarm), .i_line_on(i_line_on), .o_display(o_display));

/* tb/led_display_model.sv */
// Behavioural model of the front panel LED character display
`timescale 1ns/1ps
module led_display_model (
	// Frame from the controller
	input wire fpd_pkg::display_s i_frame,
	// What a viewer sees: nine text cells and the glyph cell
	output logic [8:0][7:0] o_text,
	output logic [7:0] o_glyph
);
	import fpd_pkg::*;
	// Any code is rendered as given; a dark panel shows nothing
	assign o_text = i_frame.lit ? i_frame.chars[8:0] : {TEXT_POS{CHAR_SPACE}};
	assign o_glyph = i_frame.lit ? i_frame.chars[9] : CHAR_SPACE;
endmodule

/* tb/tb_top.sv */
// Self-checking bench of the front panel display controller
`timescale 1ns/1ps
module tb_top;
	import fpd_pkg::*;
	localparam int STEP = 8;
	logic i_clock = 1'b0;
	logic i_nrst = 1'b0;
	regbus_s bus = '0;
	logic [31:0] rdata;
	logic [ALARM_COUNT-1:0] alarm = '0;
	logic line_on = 1'b0;
	display_s disp;
	logic [8:0][7:0] text;
	logic [7:0] glyph;
	int fail_count = 0;
	int comparisons = 0;
	logic [31:0] rv = 32'h0000_9961;
	// Clock
	always #20 i_clock = ~i_clock;
	front_panel_text_display_ctrl #(.STEP_CYCLES_P(STEP), .MSG_MAX_P(MSG_MAX)) DUT (.i_clock(i_clock),
		.i_nrst(i_nrst), .i_bus(bus), .o_rdata(rdata), .i_alarm(alarm), .i_line_on(line_on), .o_display(disp));
	led_display_model panel (.i_frame(disp), .o_text(text), .o_glyph(glyph));
	// Random source
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] t;
		t = s ^ (s << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction
	// Expected nine-cell window of a text
	function automatic logic [8:0][7:0] win(input string s, input int off);
		logic [8:0][7:0] w;
		for (int i = 0; i < TEXT_POS; i++) begin
			w[i] = (off + i < s.len()) ? s[off + i] : CHAR_SPACE;
		end
		return w;
	endfunction
	task automatic chk(input string what, input logic [79:0] seen, input logic [79:0] exp);
		comparisons++;
		if (seen !== exp) begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge i_clock);
		bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge i_clock);
		bus.wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge i_clock);
		bus <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
		@(posedge i_clock);
		bus.rd <= 1'b0;
		#1 d = rdata;
	endtask
	task automatic put_text(input logic [7:0] dl, input string s);
		wr(ADDR_TEXT_START, {24'h00_0000, dl});
		for (int i = 0; i < s.len(); i++) begin
			wr(ADDR_TEXT_CHAR, {24'h00_0000, s[i]});
		end
		wr(ADDR_TEXT_CHAR, {24'h00_0000, dl});
	endtask
	// Let a change reach the frame, then sample
	task automatic look;
		repeat (3) @(posedge i_clock);
		#1;
	endtask
	// Wait, bounded, for the visible text to move
	task automatic wait_change(output int n);
		logic [8:0][7:0] was;
		was = text;
		n = 0;
		while (text === was && n < 4 * STEP) begin
			@(posedge i_clock);
			#1 n++;
		end
	endtask
	// Align to a scroll step so a flash toggle cannot land inside a check
	task automatic sync_step;
		logic [7:0] g;
		int i;
		g = glyph;
		i = 0;
		while (glyph === g && i < 2 * STEP) begin
			@(posedge i_clock);
			#1 i++;
		end
		chk("glyph steps", glyph !== g, 1'b1);
	endtask
	task automatic tally_and_finish;
		$display("comparisons %0d mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	// Watchdog
	initial begin
		repeat (20000) @(posedge i_clock);
		fail_count++;
		tally_and_finish();
	end
	// Main sequence
	initial begin
		logic [31:0] d;
		int n;
		int k0;
		logic [8:0][7:0] prev;
		string s;
		logic seen_a;
		logic seen_b;
		repeat (12) @(posedge i_clock);
		i_nrst <= 1'b1;
		rd(ADDR_CTRL, d);
		chk("enable after power-up", d, 32'h0000_0001);
		rd(8'h20, d);
		chk("unmapped read", d, 32'h0000_0000);
		// Idle texts follow the random line switch
		repeat (4) begin
			rv = xs(rv);
			@(posedge i_clock);
			line_on <= rv[0];
			look();
			chk("idle text", text, win(rv[0] ? "System OK" : "Standby", 0));
			rd(ADDR_STATUS, d);
			chk("status idle", d, {15'h0000, rv[0], 16'h0001});
		end
		// Switch off, alarm while dark, reset command
		wr(ADDR_CTRL, 32'h0000_0000);
		@(posedge i_clock);
		alarm <= 50'h1_0000_0000;
		look();
		chk("dark panel", {disp.lit, text}, {1'b0, {TEXT_POS{CHAR_SPACE}}});
		rd(ADDR_CTRL, d);
		chk("enable query off", d, 32'h0000_0000);
		@(posedge i_clock);
		alarm <= '0;
		wr(ADDR_CTRL, 32'h0000_0002);
		rd(ADDR_CTRL, d);
		chk("enable after reset command", d, 32'h0000_0001);
		// Long user text scrolls and wraps
		s = "This is My String";
		put_text(CHAR_SQ, s);
		look();
		k0 = -1;
		for (int k = 0; k < TEXT_POS; k++) begin
			if (text === win(s, k)) begin
				k0 = k;
			end
		end
		chk("user text shown", k0 >= 0, 1'b1);
		for (int k = 1; k <= TEXT_POS; k++) begin
			wait_change(n);
			chk("scroll window", text, win(s, (k0 + k) % TEXT_POS));
			if (k > 1) begin
				chk("step length", n, STEP);
			end
		end
		// Readback doubles embedded quotes
		put_text(CHAR_SQ, "a\"b");
		s = "\"a\"\"b\"";
		for (int i = 0; i <= s.len(); i++) begin
			rd(ADDR_READBACK, d);
			chk("readback", d, (i < s.len()) ? {22'h00_0000, i == s.len() - 1, 1'b1, s[i]} : 32'h0000_0000);
		end
		// A write to the readback address starts over at the opening quote
		wr(ADDR_READBACK, 32'h0000_0000);
		rd(ADDR_READBACK, d);
		chk("readback restart", d, 32'h0000_0122);
		// Random printable characters
		repeat (3) begin
			s = "123456789";
			for (int i = 0; i < TEXT_POS; i++) begin
				rv = xs(rv);
				s[i] = 8'h20 + rv % 95;
				if (s[i] == CHAR_SQ) begin
					s[i] = 8'h41;
				end
			end
			put_text(CHAR_SQ, s);
			look();
			chk("printable text", text, win(s, 0));
		end
		// Overlong text stops at the maximum
		wr(ADDR_TEXT_START, {24'h00_0000, CHAR_DQ});
		repeat (MSG_MAX + 2) wr(ADDR_TEXT_CHAR, 32'h0000_0078);
		rd(ADDR_STATUS, d);
		chk("length capped", d[14:0], {7'h50, 8'h03});
		// Empty text blanks unless an alarm stands
		put_text(CHAR_DQ, "");
		look();
		chk("empty text", text, {TEXT_POS{CHAR_SPACE}});
		sync_step();
		@(posedge i_clock);
		alarm <= 50'h0_0000_0000_0001;
		look();
		chk("alarm over user text", text, win("+5V PS OV", 0));
		wait_change(n);
		chk("alarm flash off", text, {TEXT_POS{CHAR_SPACE}});
		wait_change(n);
		chk("alarm flash on", text, win("+5V PS OV", 0));
		// Two alarms take turns
		@(posedge i_clock);
		alarm <= 50'h0_2000_0000_0001;
		seen_a = 1'b0;
		seen_b = 1'b0;
		repeat (16 * STEP) begin
			@(posedge i_clock);
			#1 seen_a |= text === win("+5V PS OV", 0);
			seen_b |= text === win("SYSFAIL", 0);
		end
		chk("round robin", {seen_a, seen_b}, 2'h3);
		// Every alarm has its own text; a dark cycle first forces a fresh start
		sync_step();
		@(posedge i_clock);
		alarm <= '0;
		for (int i = 0; i < ALARM_COUNT; i++) begin
			@(posedge i_clock);
			alarm <= 50'h0_0000_0000_0001 << i;
			look();
			chk("alarm text present", text !== {TEXT_POS{CHAR_SPACE}}, 1'b1);
			if (i > 0) begin
				chk("alarm text distinct", text !== prev, 1'b1);
			end
			prev = text;
		end
		@(posedge i_clock);
		alarm <= '0;
		line_on <= 1'b1;
		// Clear drops the user text; enable bit kept set
		wr(ADDR_CTRL, 32'h0000_0005);
		rd(ADDR_STATUS, d);
		chk("cleared status", d[14:0], 15'h0001);
		look();
		chk("after clear", text, win("System OK", 0));
		tally_and_finish();
	end
endmodule
